// File: rtl/blalu_comb_if.sv
`timescale 1ns/1ps
interface blalu_comb_if (
    input wire logic clk,
    input wire logic rstN
);
    logic [15:0] opA;
    logic [15:0] opB;
    logic        isXor;
    logic [15:0] result;

    modport unit (input clk, input rstN, input opA, input opB, input isXor, output result);
    modport ctrl (output opA, output opB, output isXor, input result);
endinterface

// File: rtl/blalu_logic_unit.sv
`timescale 1ns/1ps
module blalu_logic_unit (
    blalu_comb_if.unit cu
);
    always_comb begin
        if (cu.isXor) begin
            cu.result = cu.opA ^ cu.opB;
        end else begin
            cu.result = cu.opA & cu.opB;
        end
    end

    // =====================================================
    // Checks
    property p_and_bits;
        @(posedge cu.clk) disable iff (!cu.rstN)
        !cu.isXor |-> ((cu.result & ~cu.opA) == 16'h0000) && ((cu.result & ~cu.opB) == 16'h0000)
            && ((cu.opA & cu.opB & ~cu.result) == 16'h0000);
    endproperty
    a_and_bits: assert property (p_and_bits) else $error("and bit mismatch");

    property p_xor_bits;
        @(posedge cu.clk) disable iff (!cu.rstN)
        cu.isXor |-> ((cu.result ^ cu.opA) == cu.opB);
    endproperty
    a_xor_bits: assert property (p_xor_bits) else $error("xor bit mismatch");
endmodule

// File: rtl/blalu_pkg.sv
package blalu_pkg;

    // =====================================================
    // Word layout (bit 15 of the instruction is the MSB)
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned OPC_HI    = 15;
    localparam int unsigned OPC_LO    = 8;
    localparam int unsigned IND1_POS  = 7;
    localparam int unsigned REG1_HI   = 6;
    localparam int unsigned REG1_LO   = 4;
    localparam int unsigned IND2_POS  = 3;
    localparam int unsigned REG2_HI   = 2;
    localparam int unsigned REG2_LO   = 0;
    localparam int unsigned SIMM_HI   = 7;
    localparam int unsigned SIMM_LO   = 4;
    localparam int unsigned SIMM_W    = 4;

    localparam logic [2:0]  NO_INDEX_REG = 3'h0;
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam logic [11:0] SIMM_UPPER   = 12'h000;

    // =====================================================
    // Opcodes
    localparam logic [7:0] OP_AND_REG_REG = 8'h25;
    localparam logic [7:0] OP_AND_MEM_MEM = 8'h65;
    localparam logic [7:0] OP_AND_MEM_REG = 8'ha5;
    localparam logic [7:0] OP_AND_DIRECT  = 8'hb5;
    localparam logic [7:0] OP_AND_SHORT   = 8'h35;
    localparam logic [7:0] OP_XOR_REG_REG = 8'h26;
    localparam logic [7:0] OP_XOR_MEM_MEM = 8'h66;
    localparam logic [7:0] OP_XOR_MEM_REG = 8'ha6;
    localparam logic [7:0] OP_XOR_DIRECT  = 8'hb6;
    localparam logic [7:0] OP_XOR_SHORT   = 8'h36;

    // =====================================================
    // Operand kinds and decode result
    typedef enum logic [1:0] {
        KIND_REG,
        KIND_MEM,
        KIND_IMM16,
        KIND_IMM4
    } blalu_kind_t;

    typedef struct packed {
        logic        valid;
        logic        isXor;
        blalu_kind_t kind1;
        blalu_kind_t kind2;
    } blalu_dec_t;

    function automatic blalu_dec_t blalu_decode(input logic [7:0] opc);
        blalu_dec_t d;
        d = '{valid: 1'b1, isXor: 1'b0, kind1: KIND_REG, kind2: KIND_REG};
        unique case (opc)
            OP_AND_REG_REG: d.isXor = 1'b0;
            OP_XOR_REG_REG: d.isXor = 1'b1;
            OP_AND_MEM_MEM, OP_XOR_MEM_MEM: begin
                d.isXor = (opc == OP_XOR_MEM_MEM);
                d.kind1 = KIND_MEM;
                d.kind2 = KIND_MEM;
            end
            OP_AND_MEM_REG, OP_XOR_MEM_REG: begin
                d.isXor = (opc == OP_XOR_MEM_REG);
                d.kind1 = KIND_MEM;
            end
            OP_AND_DIRECT, OP_XOR_DIRECT: begin
                d.isXor = (opc == OP_XOR_DIRECT);
                d.kind1 = KIND_IMM16;
            end
            OP_AND_SHORT, OP_XOR_SHORT: begin
                d.isXor = (opc == OP_XOR_SHORT);
                d.kind1 = KIND_IMM4;
            end
            default: d.valid = 1'b0;
        endcase
        return d;
    endfunction

endpackage

// File: rtl/blalu_top.sv
`timescale 1ns/1ps
// Functional notes
// - Short AND: upper twelve bits zero
// - Opcode 65: AND of two memory operands
// - AND bit is one only if both one
// - Opcode 25: AND of register/memory words
// - Register operand, or memory pointed by register
// - Result written to second operand location
// - Opcode A6: XOR memory with register operand
// - XOR bit is one when bits differ
// - Base address supports indexing and indirection
// - Opcode B6: 16-bit immediate, no indirection
// - Direct indexing adds register, wraps silently
// - Opcode 36: zero-extend 4-bit immediate
// - Opcode 66: XOR of two memory operands
module blalu_top
    import blalu_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Instruction from sequencer
    input  wire logic        start,
    input  wire logic [15:0] insWord0,
    input  wire logic [15:0] insWord1,
    input  wire logic [15:0] insWord2,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    // General register file
    output logic [2:0]       gprRdIdx,
    input  wire logic [15:0] gprRdData,
    output logic             gprWe,
    output logic [2:0]       gprWrIdx,
    output logic [15:0]      gprWrData,
    // Main storage
    output logic             memReq,
    output logic             memWe,
    output logic [15:0]      memAddr,
    output logic [15:0]      memWrData,
    input  wire logic        memAck,
    input  wire logic [15:0] memRdData
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_GPR,
        ST_PTR,
        ST_DATA,
        ST_COMB,
        ST_STORE
    } blalu_st_t;

    typedef struct packed {
        blalu_st_t   state;
        logic        sel;
        logic [15:0] word0;
        logic [15:0] base1;
        logic [15:0] base2;
        blalu_dec_t  dec;
        logic [15:0] addr;
        logic [15:0] opnd1;
        logic [15:0] opnd2;
        logic        destIsReg;
        logic [2:0]  destIdx;
        logic [15:0] destAddr;
        logic        busy;
        logic        done;
        logic        illegal;
        logic [2:0]  gprRdIdx;
        logic        gprWe;
        logic [2:0]  gprWrIdx;
        logic [15:0] gprWrData;
        logic        memReq;
        logic        memWe;
        logic [15:0] memAddr;
        logic [15:0] memWrData;
    } blalu_state_t;

    // =====================================================
    // Reset release
    logic [1:0] rstSync_reg;
    logic       rstN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    // =====================================================
    // Operand field selection
    blalu_state_t s_reg;
    blalu_state_t s_next;
    blalu_kind_t  curKind;
    logic [2:0]   curReg;
    logic         curInd;
    logic [15:0]  curBase;
    logic [15:0]  idxSum;

    always_comb begin
        curKind = s_reg.sel ? s_reg.dec.kind2 : s_reg.dec.kind1;
        curReg  = s_reg.sel ? s_reg.word0[REG2_HI:REG2_LO]
                            : s_reg.word0[REG1_HI:REG1_LO];
        curInd  = s_reg.sel ? s_reg.word0[IND2_POS] : s_reg.word0[IND1_POS];
        curBase = s_reg.sel ? s_reg.base2 : s_reg.base1;
        idxSum  = 16'(s_reg.addr + gprRdData);
    end

    blalu_comb_if combIf (.clk(clk), .rstN(rstN));

    assign combIf.opA   = s_reg.opnd1;
    assign combIf.opB   = s_reg.opnd2;
    assign combIf.isXor = s_reg.dec.isXor;

    blalu_logic_unit u_unit (.cu(combIf));

    // =====================================================
    // Sequencer
    always_comb begin
        logic        haveVal;
        logic [15:0] val;
        logic        rdMem;
        logic [15:0] rdAddr;
        s_next         = s_reg;
        s_next.done    = 1'b0;
        s_next.illegal = 1'b0;
        s_next.gprWe   = 1'b0;
        haveVal        = 1'b0;
        val            = WORD_RST;
        rdMem          = 1'b0;
        rdAddr         = WORD_RST;
        unique case (s_reg.state)
            ST_IDLE: begin
                if (start) begin
                    s_next.dec = blalu_decode(insWord0[OPC_HI:OPC_LO]);
                    s_next.word0 = insWord0;
                    s_next.base1 = insWord1;
                    s_next.base2 = insWord2;
                    s_next.sel   = 1'b0;
                    if (s_next.dec.valid) begin
                        s_next.state = ST_SETUP;
                        s_next.busy  = 1'b1;
                    end else begin
                        s_next.illegal = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                s_next.addr = curBase;
                unique case (curKind)
                    KIND_REG: begin
                        s_next.gprRdIdx = curReg;
                        s_next.state    = ST_GPR;
                    end
                    KIND_MEM: begin
                        if (curReg != NO_INDEX_REG) begin
                            s_next.gprRdIdx = curReg;
                            s_next.state    = ST_GPR;
                        end else begin
                            rdMem  = 1'b1;
                            rdAddr = curBase;
                            s_next.state = curInd ? ST_PTR : ST_DATA;
                        end
                    end
                    KIND_IMM16: begin
                        if (curReg != NO_INDEX_REG) begin
                            s_next.gprRdIdx = curReg;
                            s_next.state    = ST_GPR;
                        end else begin
                            haveVal = 1'b1;
                            val     = curBase;
                        end
                    end
                    KIND_IMM4: begin
                        haveVal = 1'b1;
                        val     = {SIMM_UPPER, s_reg.word0[SIMM_HI:SIMM_LO]};
                    end
                endcase
            end
            ST_GPR: begin
                unique case (curKind)
                    KIND_REG: begin
                        if (curInd) begin
                            rdMem  = 1'b1;
                            rdAddr = gprRdData;
                            s_next.state = ST_DATA;
                        end else begin
                            haveVal = 1'b1;
                            val     = gprRdData;
                            s_next.destIsReg = 1'b1;
                            s_next.destIdx   = curReg;
                        end
                    end
                    KIND_MEM: begin
                        rdMem  = 1'b1;
                        rdAddr = idxSum;
                        s_next.state = curInd ? ST_PTR : ST_DATA;
                    end
                    default: begin
                        haveVal = 1'b1;
                        val     = idxSum;
                    end
                endcase
            end
            ST_PTR: begin
                if (memAck) begin
                    rdMem  = 1'b1;
                    rdAddr = memRdData;
                    s_next.state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (memAck) begin
                    s_next.memReq    = 1'b0;
                    haveVal          = 1'b1;
                    val              = memRdData;
                    s_next.destIsReg = 1'b0;
                    s_next.destAddr  = s_reg.memAddr;
                end
            end
            ST_COMB: begin
                if (s_reg.destIsReg) begin
                    s_next.gprWe     = 1'b1;
                    s_next.gprWrIdx  = s_reg.destIdx;
                    s_next.gprWrData = combIf.result;
                end else begin
                    s_next.memReq    = 1'b1;
                    s_next.memWe     = 1'b1;
                    s_next.memAddr   = s_reg.destAddr;
                    s_next.memWrData = combIf.result;
                end
                s_next.state = ST_STORE;
            end
            ST_STORE: begin
                if (s_reg.destIsReg || memAck) begin
                    s_next.memReq = 1'b0;
                    s_next.memWe  = 1'b0;
                    s_next.done   = 1'b1;
                    s_next.busy   = 1'b0;
                    s_next.state  = ST_IDLE;
                end
            end
        endcase
        if (rdMem) begin
            s_next.memReq  = 1'b1;
            s_next.memWe   = 1'b0;
            s_next.memAddr = rdAddr;
            s_next.addr    = rdAddr;
        end
        if (haveVal) begin
            if (s_reg.sel) begin
                s_next.opnd2 = val;
                s_next.state = ST_COMB;
            end else begin
                s_next.opnd1 = val;
                s_next.sel   = 1'b1;
                s_next.state = ST_SETUP;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy      = s_reg.busy;
    assign done      = s_reg.done;
    assign illegal   = s_reg.illegal;
    assign gprRdIdx  = s_reg.gprRdIdx;
    assign gprWe     = s_reg.gprWe;
    assign gprWrIdx  = s_reg.gprWrIdx;
    assign gprWrData = s_reg.gprWrData;
    assign memReq    = s_reg.memReq;
    assign memWe     = s_reg.memWe;
    assign memAddr   = s_reg.memAddr;
    assign memWrData = s_reg.memWrData;

    // =====================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    property p_dec_and_mm;
        s_reg.state == ST_IDLE && start && insWord0[15:8] == 8'h65 |=>
            s_reg.dec.kind1 == KIND_MEM && s_reg.dec.kind2 == KIND_MEM && !s_reg.dec.isXor;
    endproperty
    a_dec_and_mm: assert property (p_dec_and_mm) else $error("65 decode wrong");

    property p_dec_xor_mm;
        s_reg.state == ST_IDLE && start && insWord0[15:8] == 8'h66 |=>
            s_reg.dec.kind1 == KIND_MEM && s_reg.dec.kind2 == KIND_MEM && s_reg.dec.isXor;
    endproperty
    a_dec_xor_mm: assert property (p_dec_xor_mm) else $error("66 decode wrong");

    property p_dec_and_rr;
        s_reg.state == ST_IDLE && start && insWord0[15:8] == 8'h25 |=>
            s_reg.dec.kind1 == KIND_REG && s_reg.dec.kind2 == KIND_REG && !s_reg.dec.isXor;
    endproperty
    a_dec_and_rr: assert property (p_dec_and_rr) else $error("25 decode wrong");

    property p_dec_xor_mr;
        s_reg.state == ST_IDLE && start && insWord0[15:8] == 8'ha6 |=>
            s_reg.dec.kind1 == KIND_MEM && s_reg.dec.kind2 == KIND_REG && s_reg.dec.isXor;
    endproperty
    a_dec_xor_mr: assert property (p_dec_xor_mr) else $error("a6 decode wrong");

    property p_reg_field;
        s_reg.state == ST_SETUP && !s_reg.sel && s_reg.dec.kind1 == KIND_REG |=>
            gprRdIdx == $past(s_reg.word0[6:4]) && s_reg.state == ST_GPR;
    endproperty
    a_reg_field: assert property (p_reg_field) else $error("first register field");

    property p_reg_indirect;
        s_reg.state == ST_GPR && curKind == KIND_REG && curInd |=>
            memReq && !memWe && memAddr == $past(gprRdData);
    endproperty
    a_reg_indirect: assert property (p_reg_indirect) else $error("indirect pointer");

    property p_mem_index;
        s_reg.state == ST_GPR && curKind == KIND_MEM |=>
            memReq && memAddr == $past(idxSum) && (s_reg.state == ST_PTR) == $past(curInd);
    endproperty
    a_mem_index: assert property (p_mem_index) else $error("indexed address");

    property p_direct_plain;
        s_reg.state == ST_COMB && s_reg.dec.kind1 == KIND_IMM16
            && s_reg.word0[6:4] == 3'h0 |-> s_reg.opnd1 == s_reg.base1;
    endproperty
    a_direct_plain: assert property (p_direct_plain) else $error("direct immediate");

    property p_direct_index;
        s_reg.state == ST_GPR && curKind == KIND_IMM16 |=>
            s_reg.opnd1 == 16'($past(s_reg.base1) + $past(gprRdData));
    endproperty
    a_direct_index: assert property (p_direct_index) else $error("direct index sum");

    property p_short_ext;
        s_reg.state == ST_COMB && s_reg.dec.kind1 == KIND_IMM4 |->
            s_reg.opnd1 == {12'h000, s_reg.word0[7:4]};
    endproperty
    a_short_ext: assert property (p_short_ext) else $error("short extend");

    property p_short_and;
        s_reg.state == ST_COMB && s_reg.dec.kind1 == KIND_IMM4 && !s_reg.dec.isXor |=>
            (s_reg.destIsReg ? s_reg.gprWrData[15:4] : s_reg.memWrData[15:4]) == 12'h000;
    endproperty
    a_short_and: assert property (p_short_and) else $error("short and upper");

    property p_short_xor;
        s_reg.state == ST_COMB && s_reg.dec.kind1 == KIND_IMM4 && s_reg.dec.isXor |->
            combIf.result[15:4] == s_reg.opnd2[15:4];
    endproperty
    a_short_xor: assert property (p_short_xor) else $error("short xor upper");

    property p_write_reg;
        s_reg.state == ST_COMB && s_reg.destIsReg |=>
            gprWe && gprWrIdx == $past(s_reg.destIdx) && gprWrData == $past(combIf.result) ##1 done;
    endproperty
    a_write_reg: assert property (p_write_reg) else $error("register write-back");

    property p_write_mem;
        s_reg.state == ST_COMB && !s_reg.destIsReg |=>
            memReq && memWe && memAddr == $past(s_reg.destAddr) && memWrData == $past(combIf.result);
    endproperty
    a_write_mem: assert property (p_write_mem) else $error("memory write-back");

    c_mem_mem: cover property (s_reg.state == ST_COMB && s_reg.dec.kind2 == KIND_MEM);
    c_direct_idx: cover property (s_reg.state == ST_GPR && curKind == KIND_IMM16);
    c_short_done: cover property (done && s_reg.dec.kind1 == KIND_IMM4);
    c_illegal: cover property (illegal);
endmodule

// File: tb/blalu_partner.sv
`timescale 1ns/1ps
module blalu_partner (
    // Clock, reset and storage latency
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  ackDelay,
    // General register file
    input  wire logic [2:0]  gprRdIdx,
    output logic      [15:0] gprRdData,
    input  wire logic        gprWe,
    input  wire logic [2:0]  gprWrIdx,
    input  wire logic [15:0] gprWrData,
    // Main storage
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWrData,
    output logic             memAck,
    output logic      [15:0] memRdData
);
    logic [15:0] gpr [8];
    logic [15:0] mem [64];
    logic [3:0]  waitCnt;

    // ==========================================
    // Register file, combinational read
    assign gprRdData = gpr[gprRdIdx];
    always @(posedge clk) begin
        if (gprWe) begin
            gpr[gprWrIdx] <= gprWrData;
        end
    end

    // ==========================================
    // Storage, read data shown only with the ack
    assign memRdData = memAck ? mem[memAddr[5:0]] : ~mem[memAddr[5:0]];
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memAck  <= 1'b0;
            waitCnt <= 4'h0;
        end else begin
            memAck <= 1'b0;
            if (memReq && !memAck) begin
                if (waitCnt == ackDelay) begin
                    memAck  <= 1'b1;
                    waitCnt <= 4'h0;
                    if (memWe) begin
                        mem[memAddr[5:0]] <= memWrData;
                    end
                end else begin
                    waitCnt <= waitCnt + 4'h1;
                end
            end else begin
                waitCnt <= 4'h0;
            end
        end
    end
endmodule

// File: tb/blalu_top_tb_top.sv
`timescale 1ns/1ps
module blalu_top_tb_top
    import blalu_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        start;
    logic [15:0] insWord0;
    logic [15:0] insWord1;
    logic [15:0] insWord2;
    logic        busy;
    logic        done;
    logic        illegal;
    logic [2:0]  gprRdIdx;
    logic [15:0] gprRdData;
    logic        gprWe;
    logic [2:0]  gprWrIdx;
    logic [15:0] gprWrData;
    logic        memReq;
    logic        memWe;
    logic [15:0] memAddr;
    logic [15:0] memWrData;
    logic        memAck;
    logic [15:0] memRdData;
    logic [3:0]  ackDelay;
    int          errorCnt;
    int          samplesChecked;
    logic        ill;

    blalu_top u_blalu_top (.clk(clk), .arst_n(arst_n), .start(start), .insWord0(insWord0),
        .insWord1(insWord1), .insWord2(insWord2), .busy(busy), .done(done),
        .illegal(illegal), .gprRdIdx(gprRdIdx), .gprRdData(gprRdData), .gprWe(gprWe),
        .gprWrIdx(gprWrIdx), .gprWrData(gprWrData), .memReq(memReq), .memWe(memWe),
        .memAddr(memAddr), .memWrData(memWrData), .memAck(memAck), .memRdData(memRdData));

    blalu_partner u_blalu_partner (.clk(clk), .arst_n(arst_n), .ackDelay(ackDelay),
        .gprRdIdx(gprRdIdx), .gprRdData(gprRdData), .gprWe(gprWe), .gprWrIdx(gprWrIdx),
        .gprWrData(gprWrData), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWrData(memWrData), .memAck(memAck), .memRdData(memRdData));

    // ==========================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        errorCnt++;
        summarize();
    end

    // ==========================================
    // Shared tasks
    function automatic logic [15:0] iw(logic [7:0] op, logic ind1, logic [2:0] reg1,
                                       logic ind2, logic [2:0] reg2);
        return {op, ind1, reg1, ind2, reg2};
    endfunction

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic exec(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
        int n;
        ill = 1'b0;
        @(posedge clk);
        start    <= 1'b1;
        insWord0 <= w0;
        insWord1 <= w1;
        insWord2 <= w2;
        @(posedge clk);
        start <= 1'b0;
        for (n = 0; n < 300; n++) begin
            #1;
            if (illegal === 1'b1) ill = 1'b1;
            if (n == 0 && !ill) chk(16'h0001, {15'h0000, busy});
            if (done === 1'b1 || ill) break;
            @(posedge clk);
        end
        if (n == 300) chk(16'h0001, {15'h0000, done});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regReg();
        u_blalu_partner.gpr[1] = 16'hf0f0;
        u_blalu_partner.gpr[2] = 16'hff00;
        exec(iw(OP_AND_REG_REG, 1'b0, 3'h1, 1'b0, 3'h2), 16'h0000, 16'h0000);
        chk(16'hf000, u_blalu_partner.gpr[2]);
        chk(16'hf0f0, u_blalu_partner.gpr[1]);
        u_blalu_partner.gpr[3] = 16'h0010;
        u_blalu_partner.mem[16] = 16'h1234;
        exec(iw(OP_XOR_REG_REG, 1'b0, 3'h1, 1'b1, 3'h3), 16'h0000, 16'h0000);
        chk(16'he2c4, u_blalu_partner.mem[16]);
        chk(16'h0010, u_blalu_partner.gpr[3]);
        u_blalu_partner.gpr[4] = 16'h0011;
        u_blalu_partner.mem[17] = 16'h0ff0;
        u_blalu_partner.gpr[5] = 16'h3c3c;
        exec(iw(OP_AND_REG_REG, 1'b1, 3'h4, 1'b0, 3'h5), 16'h0000, 16'h0000);
        chk(16'h0c30, u_blalu_partner.gpr[5]);
        $display("test regReg done");
    endtask

    task automatic t_memMem();
        ackDelay <= 4'h3;
        u_blalu_partner.mem[32] = 16'ha5a5;
        u_blalu_partner.mem[33] = 16'h0ff0;
        exec(iw(OP_AND_MEM_MEM, 1'b0, 3'h0, 1'b0, 3'h0), 16'h0020, 16'h0021);
        chk(16'h05a0, u_blalu_partner.mem[33]);
        u_blalu_partner.gpr[6] = 16'h0002;
        u_blalu_partner.mem[34] = 16'h3333;
        u_blalu_partner.mem[38] = 16'h0030;
        u_blalu_partner.mem[48] = 16'h5555;
        exec(iw(OP_XOR_MEM_MEM, 1'b0, 3'h6, 1'b1, 3'h6), 16'h0020, 16'h0024);
        chk(16'h6666, u_blalu_partner.mem[48]);
        chk(16'h0030, u_blalu_partner.mem[38]);
        u_blalu_partner.mem[40] = 16'h0022;
        u_blalu_partner.mem[41] = 16'h002a;
        u_blalu_partner.mem[42] = 16'hf00f;
        exec(iw(OP_AND_MEM_MEM, 1'b1, 3'h0, 1'b1, 3'h0), 16'h0028, 16'h0029);
        chk(16'h3003, u_blalu_partner.mem[42]);
        ackDelay <= 4'h0;
        $display("test memMem done");
    endtask

    task automatic t_memReg();
        logic [7:0] ops [2];
        ops = '{OP_AND_MEM_REG, OP_XOR_MEM_REG};
        u_blalu_partner.gpr[7] = 16'h0004;
        u_blalu_partner.mem[44] = 16'h0038;
        u_blalu_partner.mem[56] = 16'hc3c3;
        for (int i = 0; i < 2; i++) begin
            u_blalu_partner.gpr[1] = 16'hff0f;
            exec(iw(ops[i], 1'b1, 3'h7, 1'b0, 3'h1), 16'h0028, 16'h0000);
            chk(i ? 16'h3ccc : 16'hc303, u_blalu_partner.gpr[1]);
        end
        $display("test memReg done");
    endtask

    task automatic t_direct();
        logic [7:0] ops [2];
        ops = '{OP_AND_DIRECT, OP_XOR_DIRECT};
        u_blalu_partner.gpr[5] = 16'h0020;
        for (int i = 0; i < 2; i++) begin
            u_blalu_partner.gpr[2] = 16'hffff;
            exec(iw(ops[i], 1'b1, 3'h5, 1'b0, 3'h2), 16'hfff0, 16'h0000);
            chk(i ? 16'hffef : 16'h0010, u_blalu_partner.gpr[2]);
            u_blalu_partner.gpr[3] = 16'h0ff0;
            exec(iw(ops[i], 1'b0, 3'h0, 1'b0, 3'h3), 16'h1234, 16'h0000);
            chk(i ? 16'h1dc4 : 16'h0230, u_blalu_partner.gpr[3]);
        end
        $display("test direct done");
    endtask

    task automatic t_short();
        logic [7:0] ops [2];
        ops = '{OP_AND_SHORT, OP_XOR_SHORT};
        for (int i = 0; i < 2; i++) begin
            u_blalu_partner.gpr[2] = 16'habcd;
            exec(iw(ops[i], 1'b1, 3'h6, 1'b0, 3'h2), 16'h0000, 16'h0000);
            chk(i ? 16'habc3 : 16'h000c, u_blalu_partner.gpr[2]);
        end
        $display("test short done");
    endtask

    task automatic t_illegal();
        u_blalu_partner.gpr[2] = 16'h1357;
        exec(iw(8'h00, 1'b0, 3'h1, 1'b0, 3'h2), 16'h0000, 16'h0000);
        chk(16'h0001, {15'h0000, ill});
        chk(16'h1357, u_blalu_partner.gpr[2]);
        $display("test illegal done");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        arst_n   = 1'b0;
        start    = 1'b0;
        insWord0 = 16'h0000;
        insWord1 = 16'h0000;
        insWord2 = 16'h0000;
        ackDelay = 4'h0;
        errorCnt = 0;
        samplesChecked = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(16'h0000, {11'h000, busy, done, illegal, gprWe, memReq});
        t_regReg();
        t_memMem();
        t_memReg();
        t_direct();
        t_short();
        t_illegal();
        summarize();
    end
endmodule
